/* File: irq_timer_pkg.sv */
// shared constants for the interrupt and timer unit
package irq_timer_pkg;

  // register word indices (byte address = 4 * index)
  localparam logic [7:0] idx_main_status   = 8'h03;
  localparam logic [7:0] idx_timer_status  = 8'h05;
  localparam logic [7:0] idx_int_enable    = 8'h06;
  localparam logic [7:0] idx_int_request   = 8'h07;
  localparam logic [7:0] idx_control       = 8'h09;
  localparam logic [7:0] idx_timer_value   = 8'h0C;
  localparam logic [7:0] idx_timer_clock   = 8'h2A;
  localparam logic [7:0] idx_timer_control = 8'h2B;
  localparam logic [7:0] idx_timer_reload  = 8'h2C;
  localparam logic [7:0] idx_fifo_level    = 8'h29;
  localparam logic [7:0] idx_int_pin_setup = 8'h2D;

  // interrupt bit positions
  localparam int bit_set_clear     = 7;
  localparam int bit_timer_expired = 5;
  localparam int bit_transmit_done = 4;
  localparam int bit_receive_done  = 3;
  localparam int bit_command_done  = 2;
  localparam int bit_nearly_full   = 1;
  localparam int bit_nearly_empty  = 0;

  // main status positions
  localparam int bit_irq_summary = 3;

  // control register positions
  localparam int bit_start_now = 1;
  localparam int bit_stop_now  = 2;

  // timer clock register positions
  localparam int bit_auto_reload = 5;

  // timer control positions
  localparam int bit_start_first = 0;
  localparam int bit_start_last  = 1;
  localparam int bit_stop_first  = 2;
  localparam int bit_stop_last   = 3;

  // timer status positions
  localparam int bit_timer_active = 7;
  localparam int bit_checksum_done = 6;
  localparam int bit_nvm_done      = 5;

  // pin setup positions, reset values, divider limit, fifo depth and chip clock
  localparam int         bit_pin_invert      = 1;
  localparam int         bit_pin_drive       = 0;
  localparam logic [1:0] pin_setup_reset     = 2'h2;
  localparam logic [5:0] fifo_level_reset    = 6'h08;
  localparam logic [7:0] reload_reset        = 8'h0A;
  localparam logic [4:0] divider_reset       = 5'h07;
  localparam logic [4:0] divider_max         = 5'h15;
  localparam int         fifo_depth          = 64;
  localparam real        chip_clock_mhz      = 13.56;

  // ahb-lite transfer types
  localparam logic [1:0] htrans_nonseq = 2'h2;

endpackage

/* File: timer_bus_if.sv */
// carries timer control and status between the top and the timer
`timescale 1ns/1ns
interface timer_bus_if;
  logic       start_evt;
  logic       stop_evt;
  logic       auto_reload;
  logic [4:0] divider;
  logic [7:0] load_value;
  logic [7:0] count_value;
  logic       active;
  logic       expired;

  modport ctrl (output start_evt, stop_evt, auto_reload, divider, load_value,
                input  count_value, active, expired);
  modport tmr  (input  start_evt, stop_evt, auto_reload, divider, load_value,
                output count_value, active, expired);
endinterface

/* File: timer_unit.sv */
// reloadable down-counter with prescaler
`timescale 1ns/1ns
module timer_unit (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic clk_en,
  // control and status
  timer_bus_if.tmr  tb
);

  logic [21:0] presc_reg;
  logic [7:0]  count_reg;
  logic        active_reg;
  logic        expired_reg;

  // one tick every 2**divider chip clocks
  wire  [21:0] presc_limit = 22'((23'h1 << tb.divider) - 23'h1);
  wire         tick        = active_reg && (presc_reg >= presc_limit);
  wire         at_one      = (count_reg == 8'h01);

  assign tb.count_value = count_reg;
  assign tb.active      = active_reg;
  assign tb.expired     = expired_reg;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      presc_reg   <= 22'h000000;
      count_reg   <= 8'h00;
      active_reg  <= 1'b0;
      expired_reg <= 1'b0;
    end else if (clk_en) begin
      expired_reg <= 1'b0;
      if (tb.start_evt) begin
        // reload on every start, even while running
        count_reg  <= tb.load_value;
        active_reg <= 1'b1;
        presc_reg  <= 22'h000000;
      end else if (tb.stop_evt) begin
        active_reg <= 1'b0;
      end else if (tick) begin
        presc_reg <= 22'h000000;
        if (at_one && tb.auto_reload) begin
          count_reg   <= tb.load_value;
          expired_reg <= 1'b1;
        end else if (at_one) begin
          count_reg   <= 8'h00;
          active_reg  <= 1'b0;
          expired_reg <= 1'b1;
        end else if (count_reg != 8'h00) begin
          count_reg <= count_reg - 8'h01;
        end else begin
          active_reg <= 1'b0;
        end
      end else if (active_reg) begin
        presc_reg <= presc_reg + 22'h000001;
      end
    end
  end

endmodule // timer_unit

/* File: irq_system_and_timer_unit.sv */
// interrupt request system with timer, ahb-lite register slave
// Notes on behaviour
// - timer flag set when counter steps one to zero or reloads from one.
// - transmit flag set when transmitter enters end-of-frame.
// - transmit flag set when checksum done; checksum-done status reads one.
// - transmit flag set when nvm write done; status shows done.
// - receive flag set at end of received stream.
// - command-done flag set when command returns to idle.
// - nearly-full flag set on rising nearly-full status.
// - nearly-empty flag set on rising nearly-empty status.
// - summary bit is OR of enabled flags; drives interrupt pin.
// - hardware sets flags; host may set or clear them too.
// - bit 7 one sets written ones, zero clears written ones.
// - pin follows summary, inverted when invert control is one.
// - reset forces invert one, push-pull zero: pin undriven open drain.
// - timer clock derived from chip clock.
// - timer only sets flags, never disturbs other operations.
// - running nonzero counter decrements each timer tick.
// - with auto-reload, counter reloads after one instead of zero.
// - start loads reload value on the configured start triggers.
// - any start event reloads, even while running.
// - stop on configured receive events, zero without auto-reload, stop-now.
// - writing reload value does not disturb running counter.
// - stop-now raises no timer flag.
// - timer tick period is two to the divider in chip clocks, 0..21.
// - active status follows start and stop; count readable anytime.
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module irq_system_and_timer_unit (
  // clock, reset, enable
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // internal event sources
  input  wire logic        tx_end_of_frame,
  input  wire logic        checksum_done,
  input  wire logic        nvm_write_done,
  input  wire logic        rx_stream_end,
  input  wire logic        command_idle,
  input  wire logic [6:0]  fifo_length,
  input  wire logic        tx_first_bit,
  input  wire logic        tx_last_bit,
  input  wire logic        rx_first_bit,
  input  wire logic        rx_last_bit,
  // interrupt pin
  output logic             irq_pin_out,
  output logic             irq_pin_oe_n
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [5:0] req_reg;
  logic [5:0] en_reg;
  logic [1:0] pin_setup_reg;
  logic [5:0] fifo_threshold_reg;
  logic [7:0] load_value_reg;
  logic [5:0] timer_clock_reg;
  logic [3:0] timer_control_reg;
  logic       start_now_reg;
  logic       stop_now_reg;
  logic       full_prev_reg;
  logic       empty_prev_reg;
  logic       idle_prev_reg;
  logic       summary_reg;
  logic       wr_pend_reg;
  logic [7:0] wr_idx_reg;
  logic [5:0] req_next;
  logic [5:0] en_next;

  timer_bus_if tb ();

  timer_unit u_timer (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .clk_en  (clk_en),
    .tb      (tb)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  function automatic logic [7:0] word_index(input logic [31:0] a);
    return a[9:2];
  endfunction

  function automatic logic [5:0] set_clear(input logic [5:0] cur, input logic [7:0] wd);
    logic [5:0] m;
    m = {wd[5:0]};
    return wd[irq_timer_pkg::bit_set_clear] ? (cur | m) : (cur & ~m);
  endfunction

  wire       addr_take = hsel && hready && htrans[1] && clk_en;
  wire       wr_take   = addr_take && hwrite;
  wire       rd_take   = addr_take && !hwrite;
  wire [7:0] wd        = hwdata[7:0];
  wire       wr_req    = wr_pend_reg && clk_en && (wr_idx_reg == irq_timer_pkg::idx_int_request);
  wire       wr_en     = wr_pend_reg && clk_en && (wr_idx_reg == irq_timer_pkg::idx_int_enable);
  wire       wr_ctrl   = wr_pend_reg && clk_en && (wr_idx_reg == irq_timer_pkg::idx_control);

  ////////////////////////////////////////////////////////////////////////////
  // fifo alerts
  wire [6:0] thr7         = {1'b0, fifo_threshold_reg};
  wire [6:0] free_space   = 7'(irq_timer_pkg::fifo_depth) - fifo_length;
  wire       nearly_full  = free_space <= thr7;
  wire       nearly_empty = fifo_length <= thr7;

  ////////////////////////////////////////////////////////////////////////////
  // hardware request events, bit 5 down to bit 0
  wire [5:0] hw_set = {
    tb.expired,
    tx_end_of_frame | checksum_done | nvm_write_done,
    rx_stream_end,
    command_idle && !idle_prev_reg,
    nearly_full && !full_prev_reg,
    nearly_empty && !empty_prev_reg
  };

  always_comb begin
    req_next = req_reg;
    en_next  = en_reg;
    if (wr_req) begin
      req_next = set_clear(req_reg, wd);
    end
    if (wr_en) begin
      en_next = set_clear(en_reg, wd);
    end
    req_next = req_next | hw_set;
  end

  wire summary_next = |(req_reg & en_reg);

  ////////////////////////////////////////////////////////////////////////////
  // timer hookup; timer feeds only the flags and the timer status and value reads
  assign tb.start_evt = (tx_first_bit && timer_control_reg[irq_timer_pkg::bit_start_first]) ||
                        (tx_last_bit && timer_control_reg[irq_timer_pkg::bit_start_last]) ||
                        start_now_reg;
  assign tb.stop_evt  = (rx_first_bit && timer_control_reg[irq_timer_pkg::bit_stop_first]) ||
                        (rx_last_bit && timer_control_reg[irq_timer_pkg::bit_stop_last]) ||
                        stop_now_reg;
  assign tb.auto_reload = timer_clock_reg[irq_timer_pkg::bit_auto_reload];
  assign tb.divider     = timer_clock_reg[4:0];
  assign tb.load_value  = load_value_reg;

  ////////////////////////////////////////////////////////////////////////////
  // read mux, decoded in the address phase so data stands in the data phase
  logic [7:0] rd_byte;
  always_comb begin
    case (word_index(haddr))
      irq_timer_pkg::idx_main_status:
        rd_byte = {4'h0, summary_reg, 1'b0, nearly_full, nearly_empty};
      irq_timer_pkg::idx_timer_status:
        rd_byte = {tb.active, checksum_done, nvm_write_done, 5'h00};
      irq_timer_pkg::idx_int_enable:    rd_byte = {2'h0, en_reg};
      irq_timer_pkg::idx_int_request:   rd_byte = {2'h0, req_reg};
      irq_timer_pkg::idx_timer_value:   rd_byte = tb.count_value;
      irq_timer_pkg::idx_fifo_level:    rd_byte = {2'h0, fifo_threshold_reg};
      irq_timer_pkg::idx_timer_clock:   rd_byte = {2'h0, timer_clock_reg};
      irq_timer_pkg::idx_timer_control: rd_byte = {4'h0, timer_control_reg};
      irq_timer_pkg::idx_timer_reload:  rd_byte = load_value_reg;
      irq_timer_pkg::idx_int_pin_setup: rd_byte = {6'h00, pin_setup_reg};
      default:                          rd_byte = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus slave and configuration
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg  <= 8'h00;
      hrdata      <= 32'h00000000;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end else if (clk_en) begin
      wr_pend_reg <= wr_take;
      if (addr_take) begin
        wr_idx_reg <= word_index(haddr);
      end
      hrdata <= rd_take ? {24'h000000, rd_byte} : hrdata;
    end
  end

  wire wr_at = wr_pend_reg && clk_en;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pin_setup_reg      <= irq_timer_pkg::pin_setup_reset;
      fifo_threshold_reg <= irq_timer_pkg::fifo_level_reset;
      load_value_reg     <= irq_timer_pkg::reload_reset;
      timer_clock_reg    <= {1'b0, irq_timer_pkg::divider_reset};
      timer_control_reg  <= 4'h0;
      start_now_reg      <= 1'b0;
      stop_now_reg       <= 1'b0;
    end else if (clk_en) begin
      start_now_reg <= wr_ctrl && wd[irq_timer_pkg::bit_start_now];
      stop_now_reg  <= wr_ctrl && wd[irq_timer_pkg::bit_stop_now];
      if (wr_at && wr_idx_reg == irq_timer_pkg::idx_int_pin_setup) begin
        pin_setup_reg <= wd[1:0];
      end
      if (wr_at && wr_idx_reg == irq_timer_pkg::idx_fifo_level) begin
        fifo_threshold_reg <= wd[5:0];
      end
      if (wr_at && wr_idx_reg == irq_timer_pkg::idx_timer_reload) begin
        load_value_reg <= wd;
      end
      if (wr_at && wr_idx_reg == irq_timer_pkg::idx_timer_clock) begin
        timer_clock_reg <= {wd[5], (wd[4:0] > irq_timer_pkg::divider_max) ?
                            irq_timer_pkg::divider_max : wd[4:0]};
      end
      if (wr_at && wr_idx_reg == irq_timer_pkg::idx_timer_control) begin
        timer_control_reg <= wd[3:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags, summary and pin
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      req_reg        <= 6'h00;
      en_reg         <= 6'h00;
      full_prev_reg  <= 1'b0;
      empty_prev_reg <= 1'b0;
      idle_prev_reg  <= 1'b1;
      summary_reg    <= 1'b0;
      irq_pin_out    <= 1'b0;
      irq_pin_oe_n   <= 1'b1;
    end else if (clk_en) begin
      req_reg        <= req_next;
      en_reg         <= en_next;
      full_prev_reg  <= nearly_full;
      empty_prev_reg <= nearly_empty;
      idle_prev_reg  <= command_idle;
      summary_reg    <= summary_next;
      irq_pin_out    <= summary_next ^ pin_setup_reg[irq_timer_pkg::bit_pin_invert];
      // open drain: drive only the low level unless push-pull
      irq_pin_oe_n   <= !(pin_setup_reg[irq_timer_pkg::bit_pin_drive] ||
                          !(summary_next ^ pin_setup_reg[irq_timer_pkg::bit_pin_invert]));
    end
  end

endmodule // irq_system_and_timer_unit

/* File: irq_system_and_timer_unit_props.sv */
// concurrent checks on the ports of the interrupt and timer unit
`timescale 1ns/1ns
module irq_system_and_timer_unit_props (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        resetn,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // interrupt pin
  input wire logic        irq_pin_out,
  input wire logic        irq_pin_oe_n
);
  logic       wr_pend_reg;
  logic [7:0] wr_idx_reg;
  logic       pp_seen_reg;
  wire        take   = hsel && hready && htrans[1];
  wire        pin_wr = wr_pend_reg && (wr_idx_reg == irq_timer_pkg::idx_int_pin_setup);

  ////////////////////////////////////////////////////////////
  // write tracking
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg  <= 8'h00;
      pp_seen_reg <= 1'b0;
    end else begin
      wr_pend_reg <= take && hwrite;
      wr_idx_reg  <= haddr[9:2];
      pp_seen_reg <= pp_seen_reg || (pin_wr && hwdata[0]);
    end
  end

  ////////////////////////////////////////////////////////////
  // assertions
  chk_ready_high: assert property (@(posedge ref_clk) disable iff (!resetn) hreadyout)
    else $error("wait state inserted");
  chk_resp_okay: assert property (@(posedge ref_clk) disable iff (!resetn) !hresp)
    else $error("error response");
  chk_data_byte: assert property (@(posedge ref_clk) disable iff (!resetn)
    hrdata[31:8] == 24'h0) else $error("upper read bits set");
  chk_unmapped_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
    take && !hwrite && haddr[9:2] == 8'h3F |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  chk_rdata_holds: assert property (@(posedge ref_clk) disable iff (!resetn)
    !(take && !hwrite) |=> $stable(hrdata)) else $error("read data moved");
  chk_reset_float: assert property (@(posedge ref_clk) !resetn |=> irq_pin_oe_n)
    else $error("pin driven in reset");
  chk_release_float: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(resetn) |-> irq_pin_oe_n ##1 irq_pin_oe_n) else $error("pin driven at release");
  chk_od_low_only: assert property (@(posedge ref_clk) disable iff (!resetn)
    !pp_seen_reg && !irq_pin_oe_n |-> !irq_pin_out) else $error("open drain drove high");
  chk_pp_drives: assert property (@(posedge ref_clk) disable iff (!resetn)
    pin_wr && hwdata[0] |-> ##[1:3] !irq_pin_oe_n) else $error("push-pull not driving");
endmodule // irq_system_and_timer_unit_props

bind irq_system_and_timer_unit irq_system_and_timer_unit_props i_props (
  .ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .irq_pin_out(irq_pin_out),
  .irq_pin_oe_n(irq_pin_oe_n)
);

/* File: host_pin_model.sv */
// host side of the interrupt pin with its pull-up resistor
`timescale 1ns/1ns
module host_pin_model (
  // pin from the device
  input  wire logic irq_pin_out,
  input  wire logic irq_pin_oe_n,
  // level seen by the host
  output logic      pin_level
);
  // released open-drain pin is pulled high
  assign pin_level = irq_pin_oe_n ? 1'b1 : irq_pin_out;
endmodule // host_pin_model

/* File: irq_system_and_timer_unit_test.sv */
// self-checking bench for the interrupt and timer unit
`timescale 1ns/1ns
module irq_system_and_timer_unit_test;
  logic        ref_clk;
  logic        resetn;
  logic        clk_en;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [8:0]  src_events;
  logic [6:0]  fifo_length;
  logic        irq_pin_out;
  logic        irq_pin_oe_n;
  logic        pin_level;
  logic [7:0]  v1;
  logic [7:0]  v2;
  logic [7:0]  v3;
  int          n_fail;
  int          n_tests;
  localparam logic [7:0] src_bit [7] = '{8'h10, 8'h10, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01};

  irq_system_and_timer_unit i_dut (
    .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .tx_end_of_frame(src_events[0]), .checksum_done(src_events[1]),
    .nvm_write_done(src_events[2]), .rx_stream_end(src_events[3]),
    .command_idle(src_events[4]), .fifo_length(fifo_length),
    .tx_first_bit(src_events[5]), .tx_last_bit(src_events[6]),
    .rx_first_bit(src_events[7]), .rx_last_bit(src_events[8]),
    .irq_pin_out(irq_pin_out), .irq_pin_oe_n(irq_pin_oe_n)
  );
  host_pin_model i_host (.irq_pin_out(irq_pin_out), .irq_pin_oe_n(irq_pin_oe_n),
                         .pin_level(pin_level));

  ////////////////////////////////////////////////////////////
  // tasks
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 20) begin
        n_fail++;
        end_of_test();
      end
      @(posedge ref_clk);
    end
  endtask

  task automatic xfer(input logic [7:0] idx, input logic wr_en, input logic [7:0] wd,
                      output logic [7:0] rd);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'h0};
    htrans <= irq_timer_pkg::htrans_nonseq;
    hwrite <= wr_en;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    wait_ready();
    rd = hrdata[7:0];
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [7:0] d;
    xfer(idx, 1'b1, wd, d);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] msk, input logic [7:0] exp);
    logic [7:0] d;
    xfer(idx, 1'b0, 8'h00, d);
    check(d & msk, exp);
  endtask

  task automatic pulse(input int k);
    src_events <= 9'h001 << k;
    @(posedge ref_clk);
    src_events <= 9'h000;
    @(posedge ref_clk);
  endtask

  ////////////////////////////////////////////////////////////
  // clock and main sequence
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    n_fail = 0;
    n_tests = 0;
    resetn = 1'b0;
    clk_en = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    src_events = 9'h000;
    fifo_length = 7'h20;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    rd_chk(irq_timer_pkg::idx_int_pin_setup, 8'h03, 8'h02);
    rd_chk(8'h3F, 8'hFF, 8'h00);
    check({7'h0, irq_pin_oe_n}, 8'h01);
    $display("test reset done");
    wr(irq_timer_pkg::idx_int_enable, 8'hBF);
    rd_chk(irq_timer_pkg::idx_int_enable, 8'h3F, 8'h3F);
    wr(irq_timer_pkg::idx_int_enable, 8'h1C);
    rd_chk(irq_timer_pkg::idx_int_enable, 8'h3F, 8'h23);
    wr(irq_timer_pkg::idx_int_enable, 8'h9C);
    wr(irq_timer_pkg::idx_int_request, 8'h3F);
    rd_chk(irq_timer_pkg::idx_int_request, 8'h3F, 8'h00);
    wr(irq_timer_pkg::idx_int_request, 8'h81);
    rd_chk(irq_timer_pkg::idx_int_request, 8'h3F, 8'h01);
    rd_chk(irq_timer_pkg::idx_main_status, 8'h08, 8'h08);
    check({7'h0, pin_level}, 8'h00);
    wr(irq_timer_pkg::idx_int_pin_setup, 8'h00);
    repeat (3) @(posedge ref_clk);
    check({7'h0, irq_pin_oe_n}, 8'h01);
    wr(irq_timer_pkg::idx_int_pin_setup, 8'h01);
    repeat (3) @(posedge ref_clk);
    check({6'h0, irq_pin_oe_n, irq_pin_out}, 8'h01);
    wr(irq_timer_pkg::idx_int_request, 8'h01);
    repeat (3) @(posedge ref_clk);
    check({7'h0, pin_level}, 8'h00);
    $display("test mask and pin done");
    for (int k = 0; k < 7; k++) begin
      wr(irq_timer_pkg::idx_int_request, 8'h3F);
      if (k < 5) pulse(k);
      else fifo_length <= (k == 5) ? 7'h3C : 7'h04;
      repeat (3) @(posedge ref_clk);
      rd_chk(irq_timer_pkg::idx_int_request, 8'h3F, src_bit[k]);
    end
    src_events[3] <= 1'b1;
    wr(irq_timer_pkg::idx_int_request, 8'h08);
    src_events[3] <= 1'b0;
    rd_chk(irq_timer_pkg::idx_int_request, 8'h08, 8'h08);
    $display("test sources done");
    wr(irq_timer_pkg::idx_int_request, 8'h3F);
    wr(irq_timer_pkg::idx_timer_clock, 8'h00);
    wr(irq_timer_pkg::idx_timer_reload, 8'hFF);
    wr(irq_timer_pkg::idx_control, 8'h02);
    repeat (2) @(posedge ref_clk);
    xfer(irq_timer_pkg::idx_timer_value, 1'b0, 8'h00, v1);
    xfer(irq_timer_pkg::idx_timer_value, 1'b0, 8'h00, v2);
    check(v1 - v2, 8'h02);
    rd_chk(irq_timer_pkg::idx_timer_status, 8'h80, 8'h80);
    wr(irq_timer_pkg::idx_timer_reload, 8'h03);
    xfer(irq_timer_pkg::idx_timer_value, 1'b0, 8'h00, v3);
    check(v2 - v3, 8'h06);
    wr(irq_timer_pkg::idx_control, 8'h02);
    repeat (10) @(posedge ref_clk);
    rd_chk(irq_timer_pkg::idx_int_request, 8'h20, 8'h20);
    rd_chk(irq_timer_pkg::idx_timer_status, 8'h80, 8'h00);
    rd_chk(irq_timer_pkg::idx_timer_value, 8'hFF, 8'h00);
    wr(irq_timer_pkg::idx_int_request, 8'h20);
    wr(irq_timer_pkg::idx_timer_reload, 8'hFF);
    wr(irq_timer_pkg::idx_control, 8'h02);
    wr(irq_timer_pkg::idx_control, 8'h04);
    repeat (300) @(posedge ref_clk);
    rd_chk(irq_timer_pkg::idx_int_request, 8'h20, 8'h00);
    rd_chk(irq_timer_pkg::idx_timer_status, 8'h80, 8'h00);
    $display("test one-shot done");
    wr(irq_timer_pkg::idx_timer_clock, 8'h20);
    wr(irq_timer_pkg::idx_timer_reload, 8'h04);
    wr(irq_timer_pkg::idx_control, 8'h02);
    repeat (20) @(posedge ref_clk);
    rd_chk(irq_timer_pkg::idx_int_request, 8'h20, 8'h20);
    rd_chk(irq_timer_pkg::idx_timer_status, 8'h80, 8'h80);
    wr(irq_timer_pkg::idx_timer_clock, 8'h02);
    wr(irq_timer_pkg::idx_timer_reload, 8'hFF);
    wr(irq_timer_pkg::idx_control, 8'h02);
    repeat (2) @(posedge ref_clk);
    xfer(irq_timer_pkg::idx_timer_value, 1'b0, 8'h00, v1);
    repeat (6) @(posedge ref_clk);
    xfer(irq_timer_pkg::idx_timer_value, 1'b0, 8'h00, v2);
    check(v1 - v2, 8'h02);
    clk_en <= 1'b0;
    repeat (40) @(posedge ref_clk);
    clk_en <= 1'b1;
    xfer(irq_timer_pkg::idx_timer_value, 1'b0, 8'h00, v3);
    check(v2 - v3, 8'h00);
    wr(irq_timer_pkg::idx_control, 8'h04);
    $display("test reload and divider done");
    for (int j = 0; j < 2; j++) begin
      wr(irq_timer_pkg::idx_timer_control, (j == 0) ? 8'h05 : 8'h0A);
      pulse(5 + j);
      repeat (2) @(posedge ref_clk);
      rd_chk(irq_timer_pkg::idx_timer_status, 8'h80, 8'h80);
      pulse(7 + j);
      repeat (2) @(posedge ref_clk);
      rd_chk(irq_timer_pkg::idx_timer_status, 8'h80, 8'h00);
    end
    $display("test hardware start and stop done");
    end_of_test();
  end
endmodule // irq_system_and_timer_unit_test
